/* pfm_pkg.sv */
package pfm_pkg;

	// register indices on the plain register port
	localparam logic [3:0] PFM_REG_PA_DATA  = 4'h0;
	localparam logic [3:0] PFM_REG_PB_DATA  = 4'h1;
	localparam logic [3:0] PFM_REG_PC_DATA  = 4'h2;
	localparam logic [3:0] PFM_REG_PD_DATA  = 4'h3;
	localparam logic [3:0] PFM_REG_PA_DIR   = 4'h4;
	localparam logic [3:0] PFM_REG_PB_DIR   = 4'h5;
	localparam logic [3:0] PFM_REG_PC_DIR   = 4'h6;
	localparam logic [3:0] PFM_REG_PD_DIR   = 4'h7;
	localparam logic [3:0] PFM_REG_OPTION   = 4'h8;
	localparam logic [3:0] PFM_REG_FUNC     = 4'h9;
	localparam logic [3:0] PFM_REG_PWM_MODE = 4'hA;
	localparam logic [3:0] PFM_REG_STATUS   = 4'hB;

	// field positions
	localparam int PFM_OPT_IRQ_LEVEL_BIT  = 1;
	localparam int PFM_FUNC_SCI_EN_BIT    = 0;
	localparam int PFM_FUNC_CAP_RISE_BIT  = 1;
	localparam int PFM_PD_CMP_BIT         = 6;
	localparam int PFM_PD_RX_BIT          = 0;
	localparam int PFM_PD_TX_BIT          = 1;

	// reset values
	localparam logic [7:0] PFM_DIR_RST      = 8'h00;
	localparam logic [7:0] PFM_DATA_RST     = 8'h00;
	localparam logic       PFM_IRQ_LEVEL_RST = 1'b1;
	localparam logic [4:0] PFM_PWM_EN_RST   = 5'h00;

	// bus clock divide ratio from oscillator
	localparam int PFM_OSC_DIV = 2;

	// open-drain reset pin stretch after an internal reset source
	localparam int          PFM_RST_OUT_NS    = 20;
	localparam int          PFM_CLK_PERIOD_NS = 5;
	localparam logic [3:0]  PFM_RST_OUT_CYC   =
		4'((PFM_RST_OUT_NS + PFM_CLK_PERIOD_NS - 1) / PFM_CLK_PERIOD_NS);

	// one general port: output data and direction
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
	} pfm_port_cfg_t;

	// on-chip function requests towards port d
	typedef struct packed {
		logic       sci_en;
		logic       tx_data;
		logic [4:0] pwm_en;
		logic [4:0] pwm_out;
		logic       cmp_out;
	} pfm_func_t;

	// pin driver of one 8-bit port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pfm_pin_drv_t;

	// pwm channel n lands on this port d bit
	function automatic int pfm_pwm_bit(input int ch);
		return (ch == 4) ? 7 : ch + 2;
	endfunction

endpackage

/* pfm_port_cell.sv */
`timescale 1ns/1ps
// one 8-bit bidirectional port: pin drive and pin readback
module pfm_port_cell
	import pfm_pkg::*;
(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// configuration
	input  wire pfm_port_cfg_t cfg_i,
	input  wire logic [7:0]   fn_own_i,
	input  wire logic [7:0]   fn_out_i,
	input  wire logic [7:0]   fn_oe_i,
	// pins
	input  wire logic [7:0]   pin_i,
	output pfm_pin_drv_t      drv_o,
	output logic [7:0]        rd_o
);

	pfm_pin_drv_t drv_ff;
	pfm_pin_drv_t nxt_drv;

	// claimed bits follow the function, others the port registers
	always_comb
	begin
		nxt_drv.out = (fn_own_i & fn_out_i) | (~fn_own_i & cfg_i.data);
		nxt_drv.oe  = (fn_own_i & fn_oe_i) | (~fn_own_i & cfg_i.dir);
	end

	// registered pin drive, all inputs at reset
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			drv_ff <= '{out: PFM_DATA_RST, oe: PFM_DIR_RST};
		else
			drv_ff <= nxt_drv;
	end

	assign drv_o = drv_ff;
	// output pins read back the latch, input pins the level
	assign rd_o  = (cfg_i.dir & cfg_i.data) | (~cfg_i.dir & pin_i);

endmodule

/* pfm_edge_det.sv */
`timescale 1ns/1ps
// edge finder on one input pin
module pfm_edge_det
	import pfm_pkg::*;
#(
	parameter logic IDLE = 1'b1
)
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// pin and result
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);

	logic prev_ff;

	// keep last level; starts at the pin's idle level so reset release is no edge
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			prev_ff <= IDLE;
		else
			prev_ff <= pin_i;
	end

	assign rise_o = pin_i & ~prev_ff;
	assign fall_o = ~pin_i & prev_ff;

endmodule

/* pfm_pin_mux.sv */
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
// How it works
// - internal bus clock is an enable pulse at oscillator rate divided by two.
// - low on the reset pin forces the port, sensitivity and function registers to their start-up values.
// - watchdog or clock-monitor reset drives the reset pin low, open drain.
// - external interrupt is edge only or edge-and-level, by configuration.
// - sensitivity bit set by reset, cleared once by software, readable only as status bit 0.
// - capture event on rising or falling edge of capture pin, software chosen.
// - ports a, b, c: eight bidirectional pins each, all inputs after reset.
// - port d bits 0-5 and 7 bidirectional and shared; bit 6 output only.
// - serial enabled makes port d bit 0 a high-impedance receive input.
// - serial enabled makes port d bit 1 the transmit output.
// - enabled pulse-width channel drives its port d pin, else normal port.
module pfm_pin_mux
	import pfm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// register port
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [7:0]       reg_rdata_o,
	// oscillator and bus clock enable
	input  wire logic        osc_tick_i,
	output logic             bus_clk_en_o,
	// reset pin, open drain
	input  wire logic        reset_pin_n_i,
	input  wire logic        watchdog_timer_rst_i,
	input  wire logic        clk_monitor_rst_i,
	output logic             reset_pin_o,
	output logic             reset_pin_oe_o,
	output logic             core_rst_n_o,
	// external interrupt and timer capture
	input  wire logic        irq_pin_n_i,
	input  wire logic        timer_capture_input_i,
	output logic             irq_req_o,
	output logic             capture_evt_o,
	// on-chip functions sharing port d
	input  wire logic        serial_tx_i,
	input  wire logic [4:0]  pulse_width_channel_outputs_i,
	input  wire logic        timer_compare_i,
	output logic             serial_receive_o,
	// port pins
	input  wire logic [7:0]  port_a_pins_i,
	input  wire logic [7:0]  port_b_pins_i,
	input  wire logic [7:0]  port_c_pins_i,
	input  wire logic [7:0]  port_d_pins_i,
	output logic [7:0]       port_a_pins_o,
	output logic [7:0]       port_a_pins_oe_o,
	output logic [7:0]       port_b_pins_o,
	output logic [7:0]       port_b_pins_oe_o,
	output logic [7:0]       port_c_pins_o,
	output logic [7:0]       port_c_pins_oe_o,
	output logic [7:0]       port_d_pins_o,
	output logic [7:0]       port_d_pins_oe_o
);

	pfm_port_cfg_t cfg_ff [4];
	logic          irq_level_ff;
	logic          irq_locked_ff;
	logic          sci_en_ff;
	logic          cap_rise_ff;
	logic [4:0]    pwm_en_ff;
	logic          div_ff;
	logic          bus_clk_en_ff;
	logic [3:0]    rst_cnt_ff;
	logic          core_rst_n_ff;
	logic          irq_req_ff;
	logic          capture_ff;
	logic          rx_ff;
	logic [7:0]    rdata_ff;
	pfm_pin_drv_t  drv [4];
	logic [7:0]    rd [4];
	logic [7:0]    pin_in [4];

	// oscillator divided by two gives the bus clock enable
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			div_ff        <= 1'b0;
			bus_clk_en_ff <= 1'b0;
		end
		else
		begin
			if (osc_tick_i)
				div_ff <= ~div_ff;
			bus_clk_en_ff <= osc_tick_i & div_ff;
		end
	end
	assign bus_clk_en_o = bus_clk_en_ff;

	// internal reset sources pull the reset pin low for a stretched time
	wire int_rst = watchdog_timer_rst_i | clk_monitor_rst_i;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rst_cnt_ff <= 4'h0;
		else if (int_rst)
			rst_cnt_ff <= PFM_RST_OUT_CYC;
		else if (rst_cnt_ff != 4'h0)
			rst_cnt_ff <= rst_cnt_ff - 4'h1;
	end
	assign reset_pin_o    = 1'b0;             // open drain only sinks
	assign reset_pin_oe_o = (rst_cnt_ff != 4'h0);

	// core reset follows the pin level, registered
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			core_rst_n_ff <= 1'b0;
		else
			core_rst_n_ff <= reset_pin_n_i;
	end
	assign core_rst_n_o = core_rst_n_ff;

	// register write decode
	wire wr_opt  = reg_wr_i & (reg_addr_i == PFM_REG_OPTION);
	wire wr_func = reg_wr_i & (reg_addr_i == PFM_REG_FUNC);
	wire wr_pwm  = reg_wr_i & (reg_addr_i == PFM_REG_PWM_MODE);

	// port data and direction registers
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (int p = 0; p < 4; p++)
				cfg_ff[p] <= '{data: PFM_DATA_RST, dir: PFM_DIR_RST};
		end
		else if (!core_rst_n_ff)
		begin
			// reset pin held low: back to start-up state
			for (int p = 0; p < 4; p++)
				cfg_ff[p] <= '{data: PFM_DATA_RST, dir: PFM_DIR_RST};
		end
		else if (reg_wr_i)
		begin
			for (int p = 0; p < 4; p++)
			begin
				if (reg_addr_i == PFM_REG_PA_DATA + 4'(p))
					cfg_ff[p].data <= reg_wdata_i;
				if (reg_addr_i == PFM_REG_PA_DIR + 4'(p))
					cfg_ff[p].dir <= reg_wdata_i;
			end
		end
	end

	// sensitivity bit: set at reset, one write allowed
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			irq_level_ff  <= PFM_IRQ_LEVEL_RST;
			irq_locked_ff <= 1'b0;
		end
		else if (!core_rst_n_ff)
		begin
			irq_level_ff  <= PFM_IRQ_LEVEL_RST;
			irq_locked_ff <= 1'b0;
		end
		else if (wr_opt && !irq_locked_ff)
		begin
			irq_level_ff  <= reg_wdata_i[PFM_OPT_IRQ_LEVEL_BIT];
			irq_locked_ff <= 1'b1;
		end
	end

	// function control and pwm mode
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sci_en_ff   <= 1'b0;
			cap_rise_ff <= 1'b0;
			pwm_en_ff   <= PFM_PWM_EN_RST;
		end
		else if (!core_rst_n_ff)
		begin
			sci_en_ff   <= 1'b0;
			cap_rise_ff <= 1'b0;
			pwm_en_ff   <= PFM_PWM_EN_RST;
		end
		else
		begin
			if (wr_func)
			begin
				sci_en_ff   <= reg_wdata_i[PFM_FUNC_SCI_EN_BIT];
				cap_rise_ff <= reg_wdata_i[PFM_FUNC_CAP_RISE_BIT];
			end
			if (wr_pwm)
				pwm_en_ff <= reg_wdata_i[4:0];
		end
	end

	// interrupt and capture edges
	logic irq_rise, irq_fall, cap_rise, cap_fall;
	pfm_edge_det u_irq_edge (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.pin_i  (irq_pin_n_i),
		.rise_o (irq_rise),
		.fall_o (irq_fall)
	);
	// capture pin idles low, so its detector starts low
	pfm_edge_det #(.IDLE(1'b0)) u_cap_edge (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.pin_i  (timer_capture_input_i),
		.rise_o (cap_rise),
		.fall_o (cap_fall)
	);
	wire irq_nxt = irq_fall | (irq_level_ff & ~irq_pin_n_i);
	wire cap_nxt = cap_rise_ff ? cap_rise : cap_fall;

	// registered event outputs and receive line
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			irq_req_ff <= 1'b0;
			capture_ff <= 1'b0;
			rx_ff      <= 1'b1;
		end
		else
		begin
			irq_req_ff <= irq_nxt;
			capture_ff <= cap_nxt;
			rx_ff      <= sci_en_ff ? port_d_pins_i[PFM_PD_RX_BIT] : 1'b1;
		end
	end
	assign irq_req_o        = irq_req_ff;
	assign capture_evt_o    = capture_ff;
	assign serial_receive_o = rx_ff;

	// port d function claim map
	logic [7:0] d_own, d_out, d_oe;
	always_comb
	begin
		d_own = 8'h00;
		d_out = 8'h00;
		d_oe  = 8'h00;
		d_own[PFM_PD_RX_BIT] = sci_en_ff;
		d_oe[PFM_PD_RX_BIT]  = 1'b0;
		d_own[PFM_PD_TX_BIT] = sci_en_ff;
		d_out[PFM_PD_TX_BIT] = serial_tx_i;
		d_oe[PFM_PD_TX_BIT]  = 1'b1;
		for (int c = 0; c < 5; c++)
		begin
			d_own[pfm_pwm_bit(c)] = pwm_en_ff[c];
			d_out[pfm_pwm_bit(c)] = pulse_width_channel_outputs_i[c];
			d_oe[pfm_pwm_bit(c)]  = 1'b1;
		end
		d_own[PFM_PD_CMP_BIT] = 1'b1;
		d_out[PFM_PD_CMP_BIT] = timer_compare_i;
		d_oe[PFM_PD_CMP_BIT]  = 1'b1;
	end

	assign pin_in[0] = port_a_pins_i;
	assign pin_in[1] = port_b_pins_i;
	assign pin_in[2] = port_c_pins_i;
	assign pin_in[3] = port_d_pins_i;

	// four port cells; only port d has function claims
	for (genvar p = 0; p < 4; p++)
	begin : g_port
		pfm_port_cell u_cell (
			.clk_i    (clk_i),
			.nrst_i   (nrst_i),
			.cfg_i    (cfg_ff[p]),
			.fn_own_i ((p == 3) ? d_own : 8'h00),
			.fn_out_i ((p == 3) ? d_out : 8'h00),
			.fn_oe_i  ((p == 3) ? d_oe  : 8'h00),
			.pin_i    (pin_in[p]),
			.drv_o    (drv[p]),
			.rd_o     (rd[p])
		);
	end

	assign port_a_pins_o    = drv[0].out;
	assign port_a_pins_oe_o = drv[0].oe;
	assign port_b_pins_o    = drv[1].out;
	assign port_b_pins_oe_o = drv[1].oe;
	assign port_c_pins_o    = drv[2].out;
	assign port_c_pins_oe_o = drv[2].oe;
	assign port_d_pins_o    = drv[3].out;
	assign port_d_pins_oe_o = drv[3].oe;

	// port d read: bit 6 always the live pin level
	logic [7:0] pd_rd;
	always_comb
	begin
		pd_rd = rd[3];
		pd_rd[PFM_PD_CMP_BIT] = port_d_pins_i[PFM_PD_CMP_BIT];
	end

	// read data mux; option reads zero, sensitivity shows only in status bit 0
	logic [7:0] rd_mux;
	always_comb
	begin
		unique case (reg_addr_i)
			PFM_REG_PA_DATA:  rd_mux = rd[0];
			PFM_REG_PB_DATA:  rd_mux = rd[1];
			PFM_REG_PC_DATA:  rd_mux = rd[2];
			PFM_REG_PD_DATA:  rd_mux = pd_rd;
			PFM_REG_PA_DIR:   rd_mux = cfg_ff[0].dir;
			PFM_REG_PB_DIR:   rd_mux = cfg_ff[1].dir;
			PFM_REG_PC_DIR:   rd_mux = cfg_ff[2].dir;
			PFM_REG_PD_DIR:   rd_mux = cfg_ff[3].dir & 8'hBF;
			PFM_REG_OPTION:   rd_mux = 8'h00;
			PFM_REG_FUNC:     rd_mux = {6'h00, cap_rise_ff, sci_en_ff};
			PFM_REG_PWM_MODE: rd_mux = {3'h0, pwm_en_ff};
			PFM_REG_STATUS:   rd_mux = {5'h00, reset_pin_oe_o, irq_locked_ff, irq_level_ff};
			default:          rd_mux = 8'h00;
		endcase
	end

	// read data valid the cycle after the strobe only
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
	end
	assign reg_rdata_o = rdata_ff;

	// checks
	property p_bus_div;
		@(posedge clk_i) disable iff (!nrst_i)
		bus_clk_en_ff |=> !bus_clk_en_ff;
	endproperty
	a_bus_div: assert property (p_bus_div) else $error("bus enable not halved");

	property p_core_rst;
		@(posedge clk_i) disable iff (!nrst_i)
		!reset_pin_n_i |=> !core_rst_n_ff;
	endproperty
	a_core_rst: assert property (p_core_rst) else $error("core not reset");

	property p_rst_out;
		@(posedge clk_i) disable iff (!nrst_i)
		int_rst |=> reset_pin_oe_o && !reset_pin_o;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("reset pin not pulled");

	property p_irq_level;
		@(posedge clk_i) disable iff (!nrst_i)
		(irq_level_ff && !irq_pin_n_i) |=> irq_req_o;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("level irq lost");

	property p_irq_once;
		@(posedge clk_i) disable iff (!nrst_i)
		(irq_locked_ff && reset_pin_n_i && core_rst_n_ff) |=> $stable(irq_level_ff);
	endproperty
	a_irq_once: assert property (p_irq_once) else $error("sensitivity rewritten");

	property p_cap;
		@(posedge clk_i) disable iff (!nrst_i)
		(cap_rise_ff && cap_rise) |=> capture_evt_o;
	endproperty
	a_cap: assert property (p_cap) else $error("capture missed");

	property p_cmp_drive;
		@(posedge clk_i) disable iff (!nrst_i)
		##1 1'b1 |-> port_d_pins_oe_o[6] && port_d_pins_o[6] == $past(timer_compare_i);
	endproperty
	a_cmp_drive: assert property (p_cmp_drive) else $error("compare pin wrong");

	property p_rx_hiz;
		@(posedge clk_i) disable iff (!nrst_i)
		sci_en_ff |=> !port_d_pins_oe_o[0];
	endproperty
	a_rx_hiz: assert property (p_rx_hiz) else $error("receive pin driven");

	property p_pwm4;
		@(posedge clk_i) disable iff (!nrst_i)
		pwm_en_ff[4] |=> port_d_pins_oe_o[7] && port_d_pins_o[7] == $past(pulse_width_channel_outputs_i[4]);
	endproperty
	a_pwm4: assert property (p_pwm4) else $error("pwm4 not on bit 7");

	c_rst_out:  cover property (@(posedge clk_i) disable iff (!nrst_i) int_rst);
	c_irq_edge: cover property (@(posedge clk_i) disable iff (!nrst_i) irq_locked_ff && !irq_level_ff && irq_fall);
	c_sci:      cover property (@(posedge clk_i) disable iff (!nrst_i) sci_en_ff && wr_pwm);

endmodule

/* pfm_ext_model.sv */
`timescale 1ns/1ps
// circuits outside the pins: a weak source behind each pin, pull-up on reset
module pfm_ext_model
	import pfm_pkg::*;
(
	// device drive
	input  wire logic [3:0][7:0] out_i,
	input  wire logic [3:0][7:0] oe_i,
	input  wire logic            rst_oe_i,
	// outside sources
	input  wire logic [3:0][7:0] ext_i,
	input  wire logic            ext_cmp_en_i,
	input  wire logic            ext_rst_n_i,
	// resolved pin levels
	output logic      [3:0][7:0] pin_o,
	output logic                 rst_pin_n_o
);
	// device drive wins, except a strong signal forced onto the compare pin
	always_comb
	begin
		pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
		if (ext_cmp_en_i)
			pin_o[3][PFM_PD_CMP_BIT] = ext_i[3][PFM_PD_CMP_BIT];
	end
	// open-drain reset line, pulled up when nobody pulls it low
	assign rst_pin_n_o = ext_rst_n_i & ~rst_oe_i;
endmodule

/* test_pfm_pin_mux.sv */
`timescale 1ns/1ps
module test_pfm_pin_mux;
	import pfm_pkg::*;
	logic            clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, osc = 0;
	logic      [3:0] reg_addr_i = '0;
	logic      [7:0] reg_wdata_i = '0, d, m, rdata;
	logic            wdog = 0, cmon = 0, irq_n = 1, cap = 0, tx = 0, cmp = 0, rx;
	logic            ext_cmp_en = 0, ext_rst_n = 1, bus_en, rst_oe, core_n, irq, cev, rd_d = 0;
	logic      [4:0] pwm = 5'h1F;
	logic [3:0][7:0] ext = '0;
	wire  [3:0][7:0] pout, poe, pin;
	wire             rsn;
	logic      [7:0] exp_q[$];
	int              n_mismatch = 0, checks = 0, cycles = 0, n0, dp;
	int              n_bus = 0, n_irq = 0, n_cap = 0, n_pull = 0, n_core = 0;

	always #2.5 clk_i = ~clk_i;

	pfm_pin_mux u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(rdata), .osc_tick_i(osc), .bus_clk_en_o(bus_en),
		.reset_pin_n_i(rsn), .watchdog_timer_rst_i(wdog), .clk_monitor_rst_i(cmon),
		.reset_pin_o(), .reset_pin_oe_o(rst_oe), .core_rst_n_o(core_n),
		.irq_pin_n_i(irq_n), .timer_capture_input_i(cap), .irq_req_o(irq),
		.capture_evt_o(cev), .serial_tx_i(tx), .pulse_width_channel_outputs_i(pwm),
		.timer_compare_i(cmp), .serial_receive_o(rx),
		.port_a_pins_i(pin[0]), .port_b_pins_i(pin[1]), .port_c_pins_i(pin[2]),
		.port_d_pins_i(pin[3]), .port_a_pins_o(pout[0]), .port_a_pins_oe_o(poe[0]),
		.port_b_pins_o(pout[1]), .port_b_pins_oe_o(poe[1]), .port_c_pins_o(pout[2]),
		.port_c_pins_oe_o(poe[2]), .port_d_pins_o(pout[3]), .port_d_pins_oe_o(poe[3]));

	pfm_ext_model u_ext (.out_i(pout), .oe_i(poe), .rst_oe_i(rst_oe), .ext_i(ext),
		.ext_cmp_en_i(ext_cmp_en), .ext_rst_n_i(ext_rst_n), .pin_o(pin),
		.rst_pin_n_o(rsn));

	task automatic test_done;
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// read strobe notes its expected data for the watcher
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		exp_q.push_back(e);
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask

	// watcher: read data stands in the cycle after the strobe
	always @(posedge clk_i)
	begin
		if (rd_d && exp_q.size() > 0)
			chk("rdata", exp_q.pop_front(), rdata);
		rd_d <= reg_rd_i;
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			test_done();
		end
	end

	// pulse and level counters, sampled away from the active edge
	always @(negedge clk_i)
	begin
		if (bus_en === 1'b1) n_bus++;
		if (irq === 1'b1) n_irq++;
		if (cev === 1'b1) n_cap++;
		if (rst_oe === 1'b1) n_pull++;
		if (core_n === 1'b0) n_core++;
	end

	initial
	begin
		void'($urandom(32'h07649de2));
		ext = $urandom();
		ext[3][0] = 1'b0;
		cmp = 1'($urandom());
		cyc(4);
		nrst_i <= 1'b1;
		// ports a to c come out of reset as inputs reading the pins
		for (int p = 0; p < 3; p++)
		begin
			chk("oe rst", 8'h00, poe[p]);
			rd(PFM_REG_PA_DIR + 4'(p), 8'h00);
			rd(PFM_REG_PA_DATA + 4'(p), ext[p]);
			d = $urandom();
			m = $urandom();
			wr(PFM_REG_PA_DATA + 4'(p), d);
			wr(PFM_REG_PA_DIR + 4'(p), m);
			cyc(2);
			chk("oe", m, poe[p]);
			chk("out", d & m, pout[p] & m);
			rd(PFM_REG_PA_DATA + 4'(p), (d & m) | (ext[p] & ~m));
		end
		// port d as plain outputs; bit 6 follows the compare output only
		d = 8'($urandom()) & 8'hFC;
		tx <= 1'b1;
		wr(PFM_REG_PD_DATA, d);
		wr(PFM_REG_PD_DIR, 8'hFF);
		cyc(2);
		chk("pd oe", 8'hFF, poe[3]);
		chk("pd out", {d[7], cmp, d[5:0]}, pout[3]);
		rd(PFM_REG_PD_DIR, 8'hBF);
		rd(PFM_REG_PD_DATA, {d[7], cmp, d[5:0]});
		ext_cmp_en <= 1'b1;
		ext[3][PFM_PD_CMP_BIT] <= ~cmp;
		rd(PFM_REG_PD_DATA, {d[7], ~cmp, d[5:0]});
		ext_cmp_en <= 1'b0;
		// serial on: bit 0 becomes input despite direction, bit 1 transmits
		wr(PFM_REG_FUNC, 8'h01);
		cyc(2);
		chk("sci oe", 8'hFE, poe[3]);
		chk("tx", 8'h01, 8'(pout[3][1]));
		chk("rx", 8'h00, 8'(rx));
		wr(PFM_REG_FUNC, 8'h00);
		wr(PFM_REG_PD_DIR, 8'h00);
		cyc(2);
		chk("sci off", 8'h40, poe[3]);
		// each pulse-width channel alone, direction left at input
		for (int c = 0; c < 5; c++)
		begin
			dp = (c == 4) ? 7 : c + 2;
			wr(PFM_REG_PWM_MODE, 8'(1 << c));
			cyc(2);
			chk("pwm oe", 8'h40 | 8'(1 << dp), poe[3]);
			chk("pwm out", 8'(1 << dp), pout[3] & poe[3] & 8'hBF);
		end
		wr(PFM_REG_PWM_MODE, 8'h00);
		cyc(2);
		chk("pwm off", 8'h40, poe[3]);
		// oscillator ticking every cycle gives a bus enable every second one
		osc <= 1'b1;
		cyc(4);
		n0 = n_bus;
		cyc(20);
		chk("bus clk", 8'd10, 8'(n_bus - n0));
		osc <= 1'b0;
		// interrupt: level after reset, edge only after one write, lock
		rd(PFM_REG_OPTION, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			n0 = n_irq;
			irq_n <= 1'b0;
			cyc(10);
			chk("irq", (k == 0) ? 8'd1 : 8'd0, 8'((n_irq - n0) >= 8));
			if (k == 1) chk("irq edge", 8'd1, 8'(n_irq - n0));
			irq_n <= 1'b1;
			cyc(4);
			wr(PFM_REG_OPTION, 8'h00);
			wr(PFM_REG_OPTION, 8'h02);
		end
		// capture on the programmed edge only
		for (int e = 0; e < 2; e++)
		begin
			wr(PFM_REG_FUNC, 8'(e << PFM_FUNC_CAP_RISE_BIT));
			cyc(2);
			n0 = n_cap;
			cap <= 1'b1;
			cyc(6);
			chk("cap rise", 8'(e), 8'(n_cap - n0));
			n0 = n_cap;
			cap <= 1'b0;
			cyc(6);
			chk("cap fall", 8'(1 - e), 8'(n_cap - n0));
		end
		// watchdog, clock monitor, then an outside low on the reset pin
		for (int s = 0; s < 3; s++)
		begin
			wr(PFM_REG_PA_DIR, 8'hFF);
			n0 = n_core;
			dp = n_pull;
			wdog <= (s == 0);
			cmon <= (s == 1);
			ext_rst_n <= (s != 2);
			cyc(3);
			wdog <= 1'b0;
			cmon <= 1'b0;
			ext_rst_n <= 1'b1;
			cyc(14);
			dp = n_pull - dp;
			chk("pull", 8'(s < 2), 8'(dp >= int'(PFM_RST_OUT_CYC)));
			chk("no pull", 8'(s == 2), 8'(dp == 0));
			chk("core rst", 8'd1, 8'(n_core > n0));
			rd(PFM_REG_PA_DIR, 8'h00);
		end
		cyc(3);
		test_done();
	end
endmodule
